/* File: rtl/cidk_top.sv */
// Caller-ID tone keying coefficient control with its register slave.
// Assumes the oscillator timer expiry and the bit to send are
// synchronous to clk, and that software uses Avalon-MM with waitrequest.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps

// How it works
// - Keying only when both enable bits set.
// - Space expiry loads space amplitude coefficient.
// - Space expiry loads space frequency coefficient.
// - Mark expiry loads mark amplitude coefficient.
// - Mark expiry loads mark frequency coefficient.
// - Space-to-mark scales amplitude by rise gain.
// - Mark-to-space scales amplitude by fall gain.
// - Each coefficient is one whole 16-bit register.
module cidk_top
    import cidk_pkg::*;
#(
    parameter int unsigned ADDR_W = 10
)
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Avalon-MM register slave.
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // Oscillator timer and bit source.
    input  wire logic              osc_one_timer_expire,
    input  wire logic              tx_bit,
    // Normal oscillator settings, used outside keying mode.
    input  wire logic [15:0]       osc_one_amplitude_in,
    input  wire logic [15:0]       osc_one_frequency_in,
    // Values loaded into oscillator 1.
    output logic [15:0]            osc_one_amplitude,
    output logic [15:0]            osc_one_frequency,
    output logic                   osc_one_load
);

    // Coefficient registers.
    logic [15:0] space_amplitude_coef_r;   // Amplitude for a space.
    logic [15:0] space_frequency_coef_r;   // Frequency for a space.
    logic [15:0] mark_amplitude_coef_r;    // Amplitude for a mark.
    logic [15:0] mark_frequency_coef_r;    // Frequency for a mark.
    logic [15:0] rise_transition_gain_r;   // Factor on space to mark.
    logic [15:0] fall_transition_gain_r;   // Factor on mark to space.

    // Enable bits.
    logic        keying_enable_r;            // Keying mode request.
    logic        oscillator_reload_enable_r; // Oscillator reload enable.
    logic        enhanced;                   // Both enables set.

    // Bus handshake.
    logic        ack_r;                 // Answer given this cycle.
    logic        req;                   // A read or a write is pending.
    logic        take;                  // Request accepted at this edge.
    logic [7:0]  idx;                   // Register index from address.
    logic        hit;                   // Index maps to a register.
    logic [31:0] rd_mux;                // Read data before the register.
    logic [15:0] wr_lo;                 // Low half merged with lanes.

    // Sequencer.
    cidk_seq_e   state_r;               // Reload sequencer state.
    cidk_seq_e   state_nxt;             // Its next value.
    logic        last_bit_r;            // Bit sent in the last period.
    logic        corr_r;                // Last reload had a correction.
    logic [15:0] freq_hold_r;           // Frequency waiting for load.
    logic        sel_mark;              // Mark set chosen.
    logic        change;                // Bit differs from last one.

    // Link to the gain multiplier.
    cidk_mul_if  mul_bus ();

    // Multiplier instance.
    cidk_gain_mul cidk_gain_mul_i
    (
        .clk   (clk),
        .rst_n (rst_n),
        .m     (mul_bus.mul)
    );

    // Keying runs only while both enables are set.
    assign enhanced = keying_enable_r & oscillator_reload_enable_r;

    // Request decode; one wait cycle before each answer.
    assign req             = avs_read | avs_write;
    assign take            = req & ack_r;
    assign avs_waitrequest = req & ~ack_r;
    assign idx             = avs_address[9:2];

    // Acknowledge one cycle after a request appears, then drop.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= req & ~ack_r;
        end
    end

    // Merge byte lanes into the low half of a register.
    function automatic logic [15:0] merge16
    (
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [15:0] v;
        v = old;
        if (be[0])
        begin
            v[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction : merge16

    // Shared merge helper for the coefficient being written.
    always_comb
    begin
        case (idx)
            IDX_SPACE_AMP:  wr_lo = space_amplitude_coef_r;
            IDX_SPACE_FREQ: wr_lo = space_frequency_coef_r;
            IDX_MARK_AMP:   wr_lo = mark_amplitude_coef_r;
            IDX_MARK_FREQ:  wr_lo = mark_frequency_coef_r;
            IDX_RISE_GAIN:  wr_lo = rise_transition_gain_r;
            IDX_FALL_GAIN:  wr_lo = fall_transition_gain_r;
            default:        wr_lo = 16'h0000;
        endcase
        wr_lo = merge16(wr_lo, avs_writedata, avs_byteenable);
    end

    // Coefficient writes; only the enabled byte lanes of the register change.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            space_amplitude_coef_r <= COEF_RST;
            space_frequency_coef_r <= COEF_RST;
            mark_amplitude_coef_r  <= COEF_RST;
            mark_frequency_coef_r  <= COEF_RST;
            rise_transition_gain_r <= COEF_RST;
            fall_transition_gain_r <= COEF_RST;
        end
        else if (take && avs_write)
        begin
            case (idx)
                IDX_SPACE_AMP:  space_amplitude_coef_r <= wr_lo;
                IDX_SPACE_FREQ: space_frequency_coef_r <= wr_lo;
                IDX_MARK_AMP:   mark_amplitude_coef_r  <= wr_lo;
                IDX_MARK_FREQ:  mark_frequency_coef_r  <= wr_lo;
                IDX_RISE_GAIN:  rise_transition_gain_r <= wr_lo;
                IDX_FALL_GAIN:  fall_transition_gain_r <= wr_lo;
                default:        ;
            endcase
        end
    end

    // Enable bit writes; only byte lane 0 carries bit 6.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            keying_enable_r            <= 1'b0;
            oscillator_reload_enable_r <= 1'b0;
        end
        else if (take && avs_write && avs_byteenable[0])
        begin
            if (idx == IDX_KEYING)
            begin
                keying_enable_r <= avs_writedata[ENABLE_BIT];
            end
            if (idx == IDX_RELOAD)
            begin
                oscillator_reload_enable_r <= avs_writedata[ENABLE_BIT];
            end
        end
    end

    // Read multiplexer; unmapped indices read as zero.
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        hit    = 1'b1;
        case (idx)
            IDX_SPACE_AMP:  rd_mux[15:0] = space_amplitude_coef_r;
            IDX_SPACE_FREQ: rd_mux[15:0] = space_frequency_coef_r;
            IDX_MARK_AMP:   rd_mux[15:0] = mark_amplitude_coef_r;
            IDX_MARK_FREQ:  rd_mux[15:0] = mark_frequency_coef_r;
            IDX_RISE_GAIN:  rd_mux[15:0] = rise_transition_gain_r;
            IDX_FALL_GAIN:  rd_mux[15:0] = fall_transition_gain_r;
            IDX_KEYING:     rd_mux[ENABLE_BIT] = keying_enable_r;
            IDX_RELOAD:     rd_mux[ENABLE_BIT] = oscillator_reload_enable_r;
            IDX_STATUS:
            begin
                rd_mux[ST_ENH]  = enhanced;
                rd_mux[ST_LAST] = last_bit_r;
                rd_mux[ST_CORR] = corr_r;
                rd_mux[ST_BUSY] = (state_r != SEQ_IDLE);
            end
            default:        hit = 1'b0;
        endcase
        if (!hit)
        begin
            rd_mux = 32'h0000_0000;
        end
    end

    // Read data come from a register, loaded while the answer is pending.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (avs_read && !ack_r)
        begin
            avs_readdata <= rd_mux;
        end
    end

    // Pending bit picks the set; a change from the last bit corrects.
    assign sel_mark = tx_bit;
    assign change   = tx_bit != last_bit_r;

    // Request to the multiplier at timer expiry.
    always_comb
    begin
        mul_bus.start = (state_r == SEQ_IDLE) && osc_one_timer_expire;
        mul_bus.amp   = osc_one_amplitude_in;
        mul_bus.gain  = 16'h0000;
        mul_bus.apply = 1'b0;
        if (enhanced)
        begin
            if (sel_mark)
            begin
                mul_bus.amp   = mark_amplitude_coef_r;
                mul_bus.gain  = rise_transition_gain_r;
            end
            else
            begin
                mul_bus.amp   = space_amplitude_coef_r;
                mul_bus.gain  = fall_transition_gain_r;
            end
            mul_bus.apply = change;
        end
    end

    // Sequencer next state: expiry, multiply, load.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SEQ_IDLE:
            begin
                if (osc_one_timer_expire)
                begin
                    state_nxt = SEQ_MUL;
                end
            end
            SEQ_MUL:
            begin
                if (mul_bus.done)
                begin
                    state_nxt = SEQ_LOAD;
                end
            end
            SEQ_LOAD: state_nxt = SEQ_IDLE;
            default:  state_nxt = SEQ_IDLE;
        endcase
    end

    // Sequencer state register.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= SEQ_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Capture the frequency and bit history at expiry.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            freq_hold_r <= 16'h0000;
            last_bit_r  <= LAST_RST;
            corr_r      <= 1'b0;
        end
        else if (mul_bus.start)
        begin
            if (!enhanced)
            begin
                freq_hold_r <= osc_one_frequency_in;
                corr_r      <= 1'b0;
            end
            else
            begin
                if (sel_mark)
                begin
                    freq_hold_r <= mark_frequency_coef_r;
                end
                else
                begin
                    freq_hold_r <= space_frequency_coef_r;
                end
                last_bit_r <= tx_bit;
                corr_r     <= change;
            end
        end
    end

    // Load oscillator 1 once the amplitude is ready.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            osc_one_amplitude <= 16'h0000;
            osc_one_frequency <= 16'h0000;
            osc_one_load      <= 1'b0;
        end
        else
        begin
            osc_one_load <= mul_bus.done;
            if (mul_bus.done)
            begin
                osc_one_amplitude <= mul_bus.result;
                osc_one_frequency <= freq_hold_r;
            end
        end
    end

endmodule : cidk_top

/* File: rtl/cidk_pkg.sv */
// Constants shared by the caller-ID tone keying block.
// Assumes a 32-bit Avalon-MM register bus with word-aligned registers.
package cidk_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_SPACE_AMP  = 8'h45;
    localparam logic [7:0] IDX_SPACE_FREQ = 8'h46;
    localparam logic [7:0] IDX_MARK_AMP   = 8'h47;
    localparam logic [7:0] IDX_MARK_FREQ  = 8'h48;
    localparam logic [7:0] IDX_RISE_GAIN  = 8'h49;
    localparam logic [7:0] IDX_FALL_GAIN  = 8'h4a;
    localparam logic [7:0] IDX_STATUS     = 8'h4b;
    localparam logic [7:0] IDX_RELOAD     = 8'h20;
    localparam logic [7:0] IDX_KEYING     = 8'h6c;

    // Bit position of both enable bits in their registers.
    localparam int unsigned ENABLE_BIT = 6;

    // Coefficient width and reset value.
    localparam int unsigned COEF_W     = 16;
    localparam logic [15:0] COEF_RST   = 16'h0000;

    // Fraction bits of a gain in the transition correction format.
    localparam int unsigned GAIN_FRAC  = 14;

    // Status register bit positions.
    localparam int unsigned ST_ENH     = 0;
    localparam int unsigned ST_LAST    = 1;
    localparam int unsigned ST_CORR    = 2;
    localparam int unsigned ST_BUSY    = 3;

    // Line idles at mark before the first bit is keyed.
    localparam logic        LAST_RST   = 1'b1;

    // Reload sequencer states, Gray coded from SEQ_IDLE through SEQ_LOAD; SEQ_LOAD back to SEQ_IDLE flips both bits.
    typedef enum logic [1:0]
    {
        SEQ_IDLE = 2'b00,
        SEQ_MUL  = 2'b01,
        SEQ_LOAD = 2'b11
    } cidk_seq_e;

endpackage : cidk_pkg

/* File: rtl/cidk_mul_if.sv */
// Carrier between the keying sequencer and its gain multiplier.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface cidk_mul_if;
    logic        start;    // One-cycle request.
    logic [15:0] amp;      // Amplitude to be corrected.
    logic [15:0] gain;     // Correction factor.
    logic        apply;    // Apply the factor, else pass amplitude.
    logic [15:0] result;   // Registered corrected amplitude.
    logic        done;     // One-cycle completion pulse.

    modport seq (output start, amp, gain, apply, input result, done);
    modport mul (input start, amp, gain, apply, output result, done);
endinterface : cidk_mul_if

/* File: rtl/cidk_gain_mul.sv */
// Gain multiplier for the oscillator amplitude.
// Assumes an unsigned factor with GAIN_FRAC fraction bits.
`timescale 1ns/100ps
module cidk_gain_mul
    import cidk_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Request and answer.
    cidk_mul_if.mul   m
);

    // Full product of amplitude and factor.
    logic [31:0] prod;
    // Scaled product, saturated to 16 bits.
    logic [15:0] scaled;

    // Scale down the product and clamp any overflow.
    always_comb
    begin
        prod   = m.amp * m.gain;
        scaled = prod[GAIN_FRAC +: 16];
        if (prod[31:GAIN_FRAC + 16] != '0)
        begin
            scaled = 16'hffff;
        end
    end

    // Register the answer one cycle after the request.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            m.result <= 16'h0000;
            m.done   <= 1'b0;
        end
        else
        begin
            m.done <= m.start;
            if (m.start)
            begin
                m.result <= m.apply ? scaled : m.amp;
            end
        end
    end

endmodule : cidk_gain_mul

/* File: sim/cidk_asserts.sv */
// Checker for the keying block: bus timing, reload timing, coefficient choice.
// Assumes it sees only the top ports and shadows registers from bus writes.
`timescale 1ns/100ps
module cidk_asserts
    import cidk_pkg::*;
#(
    parameter int unsigned ADDR_W = 10
)
(
    // Clock and reset.
    input wire logic              clk,
    input wire logic              rst_n,
    // Register bus.
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    // Keying side.
    input wire logic              osc_one_timer_expire,
    input wire logic              tx_bit,
    input wire logic [15:0]       osc_one_amplitude_in,
    input wire logic [15:0]       osc_one_frequency_in,
    input wire logic [15:0]       osc_one_amplitude,
    input wire logic [15:0]       osc_one_frequency,
    input wire logic              osc_one_load
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] c_r [4];  // Shadow amplitude and frequency coefficients.
    logic        rel_r;    // Shadow reload enable.
    logic        key_r;    // Shadow keying enable.
    logic        last_r;   // Last keyed bit.
    logic        e1_r;     // Expiry one cycle ago.
    logic        e2_r;     // Expiry two cycles ago.
    wire  [7:0]  idx = avs_address[9:2];
    wire         wr  = avs_write && !avs_waitrequest;
    wire         acc = osc_one_timer_expire && !e1_r && !e2_r;  // Expiry taken.
    wire         enh = rel_r && key_r;
    // Follows accepted writes and the bit history, as the block should.
    always_ff @(posedge clk)
    begin
        e1_r <= osc_one_timer_expire && rst_n;
        e2_r <= e1_r && rst_n;
        if (!rst_n)
        begin
            rel_r  <= 1'b0;
            key_r  <= 1'b0;
            last_r <= LAST_RST;
            c_r    <= '{default: COEF_RST};
        end
        else
        begin
            if (wr && avs_byteenable[0] && idx == IDX_RELOAD) rel_r <= avs_writedata[ENABLE_BIT];
            if (wr && avs_byteenable[0] && idx == IDX_KEYING) key_r <= avs_writedata[ENABLE_BIT];
            // Only the enabled byte lanes of a coefficient change.
            if (wr && idx >= IDX_SPACE_AMP && idx <= IDX_MARK_FREQ)
            begin
                if (avs_byteenable[0])
                    c_r[2'(idx - IDX_SPACE_AMP)][7:0] <= avs_writedata[7:0];
                if (avs_byteenable[1])
                    c_r[2'(idx - IDX_SPACE_AMP)][15:8] <= avs_writedata[15:8];
            end
            if (acc && enh) last_r <= tx_bit;
        end
    end
    // A keyed expiry of a given bit after a given last bit.
    sequence s_key(b, l);
        acc && enh && tx_bit == b && last_r == l;
    endsequence
    // The load pulse is sampled high two edges after the accepted expiry.
    sequence s_load;
        ##2 osc_one_load;
    endsequence
    AST_NORMAL: assert property (acc && !enh |-> s_load ##0
        osc_one_amplitude == $past(osc_one_amplitude_in, 2)
        && osc_one_frequency == $past(osc_one_frequency_in, 2))
        else $error("Normal settings not loaded.");
    AST_SPACE_AMP: assert property (s_key(0, 0) |-> s_load ##0
        osc_one_amplitude == $past(c_r[0], 2)) else $error("Space amplitude wrong.");
    AST_SPACE_FREQ: assert property (acc && enh && !tx_bit |-> s_load ##0
        osc_one_frequency == $past(c_r[1], 2)) else $error("Space frequency wrong.");
    AST_MARK_AMP: assert property (s_key(1, 1) |-> s_load ##0
        osc_one_amplitude == $past(c_r[2], 2)) else $error("Mark amplitude wrong.");
    AST_MARK_FREQ: assert property (acc && enh && tx_bit |-> s_load ##0
        osc_one_frequency == $past(c_r[3], 2)) else $error("Mark frequency wrong.");
    AST_CAUSE: assert property (osc_one_load |-> $past(acc, 2))
        else $error("Load without expiry.");
    AST_HOLD: assert property (!osc_one_load |-> $stable(osc_one_amplitude)
        && $stable(osc_one_frequency)) else $error("Outputs moved without load.");
    AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("Bus answer late.");
    AST_UPPER: assert property (avs_read && !avs_waitrequest
        |-> avs_readdata[31:16] == 16'h0000) else $error("Upper read bits set.");
    AST_READBACK: assert property (avs_read && !avs_waitrequest && idx == IDX_MARK_AMP
        |-> avs_readdata[15:0] == c_r[2]) else $error("Coefficient readback wrong.");
endmodule : cidk_asserts

/* File: sim/cidk_top_test.sv */
// Self-checking bench: register access, pass-through and keyed reloads.
// Assumes one clock; the block answers each bus request after a wait cycle.
`timescale 1ns/100ps
module cidk_top_test
    import cidk_pkg::*;
;
    localparam logic [15:0] CV [6] = '{16'h1000, 16'h0aaa, 16'h6000,
                                       16'h0555, 16'h8000, 16'h2000};
    localparam logic [15:0] AMP_IN  = 16'h3333;  // Normal amplitude.
    localparam logic [15:0] FREQ_IN = 16'h4444;  // Normal frequency.
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        osc_one_timer_expire = 1'b0;
    logic        tx_bit = 1'b1;
    logic [15:0] osc_one_amplitude;
    logic [15:0] osc_one_frequency;
    logic        osc_one_load;
    logic [31:0] rdv;               // Last read value.
    logic        last_m = LAST_RST; // Expected last keyed bit.
    logic [15:0] rg = CV[4];        // Expected rise gain.
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    cidk_top cidk_top_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .osc_one_timer_expire(osc_one_timer_expire),
        .tx_bit(tx_bit), .osc_one_amplitude_in(AMP_IN), .osc_one_frequency_in(FREQ_IN),
        .osc_one_amplitude(osc_one_amplitude), .osc_one_frequency(osc_one_frequency),
        .osc_one_load(osc_one_load));
    always #10 clk = ~clk;
    // Cuts a hang short.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            errors = errors + 1;
            end_of_test();
        end
    end
    // Prints the counts and the verdict, then stops.
    task end_of_test;
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // Compares one value and counts it.
    task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    // One bus cycle; holds the request until waitrequest is seen low.
    task bus(input logic w, input logic [7:0] i, input logic [15:0] d);
        @(posedge clk);
        avs_address <= {i, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {~d, d};
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    // Gain correction with saturation, in the unsigned fixed point format.
    function automatic logic [15:0] scale(input logic [15:0] a, input logic [15:0] g);
        logic [31:0] p;
        p = (32'(a) * 32'(g)) >> GAIN_FRAC;
        return (p > 32'h0000ffff) ? 16'hffff : p[15:0];
    endfunction : scale
    // One timer expiry for bit b; en says whether keying is expected.
    task pulse(input logic b, input logic en);
        logic [15:0] ea;
        logic [15:0] ef;
        ea = b ? CV[2] : CV[0];
        ef = b ? CV[3] : CV[1];
        if (!en)
        begin
            ea = AMP_IN;
            ef = FREQ_IN;
        end
        else if (b !== last_m)
            ea = scale(ea, b ? rg : CV[5]);
        if (en)
            last_m = b;
        @(posedge clk);
        tx_bit <= b;
        osc_one_timer_expire <= 1'b1;
        @(posedge clk);
        osc_one_timer_expire <= 1'b0;
        while (osc_one_load !== 1'b1)
            @(posedge clk);
        check("amplitude", {16'h0, osc_one_amplitude}, {16'h0, ea});
        check("frequency", {16'h0, osc_one_frequency}, {16'h0, ef});
    endtask : pulse
    // Reset values, write and read back, and an unmapped index.
    task t_regs;
        for (int k = 0; k < 6; k++)
        begin
            bus(1'b0, 8'(IDX_SPACE_AMP + k), 16'h0000);
            check("coef reset", rdv, {16'h0, COEF_RST});
            bus(1'b1, 8'(IDX_SPACE_AMP + k), CV[k]);
        end
        for (int k = 0; k < 6; k++)
        begin
            bus(1'b0, 8'(IDX_SPACE_AMP + k), 16'h0000);
            check("coef readback", rdv, {16'h0, CV[k]});
        end
        // A write on lane 0 alone leaves the upper byte untouched.
        avs_byteenable <= 4'h1;
        bus(1'b1, IDX_MARK_AMP, 16'h12ab);
        avs_byteenable <= 4'hf;
        bus(1'b0, IDX_MARK_AMP, 16'h0000);
        check("lane write", rdv, {16'h0, CV[2][15:8], 8'hab});
        bus(1'b1, IDX_MARK_AMP, CV[2]);
        bus(1'b1, 8'h50, 16'hbeef);
        bus(1'b0, 8'h50, 16'h0000);
        check("unmapped read", rdv, 32'h0);
    endtask : t_regs
    // Enables one at a time, then a bit stream with corrections and saturation.
    task t_keying;
        localparam logic [5:0] SEQ = 6'b011001;
        bus(1'b1, IDX_RELOAD, 16'h0040);
        pulse(1'b1, 1'b0);
        bus(1'b1, IDX_KEYING, 16'h0040);
        for (int k = 0; k < 6; k++)
            pulse(SEQ[k], 1'b1);
        rg = 16'hc000;
        bus(1'b1, IDX_RISE_GAIN, rg);
        pulse(1'b1, 1'b1);
        pulse(1'b0, 1'b1);
        bus(1'b1, IDX_KEYING, 16'h0000);
        pulse(1'b1, 1'b0);
        bus(1'b1, IDX_KEYING, 16'h0040);
        bus(1'b1, IDX_RELOAD, 16'h0000);
        pulse(1'b1, 1'b0);
        bus(1'b1, IDX_RELOAD, 16'h0040);
        pulse(1'b1, 1'b1);
        // Status after a corrected mark reload: enhanced, last mark, corrected, idle.
        bus(1'b0, IDX_STATUS, 16'h0000);
        check("status", rdv, 32'((1 << ST_ENH) | (1 << ST_LAST) | (1 << ST_CORR)));
        bus(1'b0, IDX_KEYING, 16'h0000);
        check("keying enable", rdv, 32'(1 << ENABLE_BIT));
    endtask : t_keying
    // Main sequence.
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_keying();
        end_of_test();
    end
endmodule : cidk_top_test
bind cidk_top cidk_asserts #(.ADDR_W(ADDR_W)) cidk_asserts_i (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .osc_one_timer_expire(osc_one_timer_expire), .tx_bit(tx_bit),
    .osc_one_amplitude_in(osc_one_amplitude_in), .osc_one_frequency_in(osc_one_frequency_in),
    .osc_one_amplitude(osc_one_amplitude), .osc_one_frequency(osc_one_frequency),
    .osc_one_load(osc_one_load));
